// ===== design/pfmux_pkg.sv
package pfmux_pkg;
  // Memory data bus geometry.
  localparam int MD_WIDTH = 64;
  localparam int STRAP_BIT = 28;
  localparam int ROM_ADDR_W = 16;
  localparam int ROM_BYTE_LO = 16;
  localparam int ROM_BYTE_W = 8;
  localparam int STROBE_W = 8;
  localparam int ADDR_HI = 11;
  // Strap level that selects the video-module pin functions.
  localparam logic STRAP_MODULE = 1'b1;
  // Feature-connector operating modes.
  typedef enum logic [1:0] {
    PFMUX_FC_STANDARD,
    PFMUX_FC_PROPRIETARY,
    PFMUX_FC_DIRECT
  } pfmux_fc_mode_t;
endpackage

// ===== design/pfmux_strap.sv
`timescale 1ns/1ps
module pfmux_strap (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Strap level and held selection.
  input wire logic strapIn,
  output logic strapHeld
);
  logic strapHeld_q;
  logic inReset_q;
  // -------------------------------------------------------------------
  // Strap capture
  // -------------------------------------------------------------------
  // The strap is sampled on clock edges while reset is low and on the
  // first edge after release, then frozen; asynchronous reset loads only
  // constants, so the level itself is always taken by a clocked edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      inReset_q <= 1'b1;
    end else begin
      inReset_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n || inReset_q) begin
      strapHeld_q <= strapIn;
    end
  end
  assign strapHeld = strapHeld_q;
endmodule // pfmux_strap

// ===== design/pfmux_pin_function_mux.sv
`timescale 1ns/1ps
// Functional notes
// - Pin is decoder luma enable (low) or module video-active, by strap.
// - Pin is decoder chroma enable (low) or module select (low), by strap.
// - Input pin is decoder pixel clock or module interrupt, by strap.
// - ROM access puts 16-bit ROM address on data lines 15..0.
// - ROM read byte arrives on data lines 23..16 and is taken there.
// - In shared memory, ROM select pin becomes urgent request (low).
// - Normal DRAM: eight strobes per bank pair, one write enable each.
// - One-strobe DRAM: strobe pins become byte write enables, swapped.
// - Bank 2-3 strobes share upper video pins; used only in 64-bit mode.
// - Address bits 11..1 shared; bit 0 separate per bank pair.
// - Direct or proprietary modes: sync enable pin is input vsync.
// - Direct or proprietary modes: clock enable pin is input field.
// - Standard mode: accept sync, clock, data only while enable low.
module pfmux_pin_function_mux (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration.
  input wire logic oneStrobeDram,
  input wire logic interleave64,
  input wire logic sharedMemOn,
  input wire pfmux_pkg::pfmux_fc_mode_t fcMode,
  // Internal video-path controls.
  input wire logic lumaOutEnN,
  input wire logic chromaOutEnN,
  input wire logic moduleVideoActive,
  input wire logic moduleSelectN,
  // Internal memory controller side.
  input wire logic [pfmux_pkg::STROBE_W-1:0] bank01ColStrobeN,
  input wire logic [pfmux_pkg::STROBE_W-1:0] bank23ColStrobeN,
  input wire logic bank01WriteEnN,
  input wire logic bank23WriteEnN,
  input wire logic [pfmux_pkg::STROBE_W-1:0] bank01ByteWrN,
  input wire logic [pfmux_pkg::STROBE_W-1:0] bank23ByteWrN,
  input wire logic [pfmux_pkg::ADDR_HI:0] memAddr,
  input wire logic [pfmux_pkg::ADDR_HI:0] memAddrB,
  input wire logic [pfmux_pkg::MD_WIDTH-1:0] memWrData,
  input wire logic [pfmux_pkg::MD_WIDTH-1:0] memWrOe,
  input wire logic [pfmux_pkg::STROBE_W-1:0] videoHiOut,
  input wire logic videoHiOe,
  // BIOS ROM and shared memory side.
  input wire logic romAccess,
  input wire logic [pfmux_pkg::ROM_ADDR_W-1:0] biosRomAddr,
  input wire logic romSelectN,
  input wire logic urgentSharedMemReqN,
  // Pins: memory data bus.
  input wire logic [pfmux_pkg::MD_WIDTH-1:0] memDataBusIn,
  output logic [pfmux_pkg::MD_WIDTH-1:0] memDataBusOut,
  output logic [pfmux_pkg::MD_WIDTH-1:0] memDataBusOe,
  // Pins: DRAM control.
  output logic [pfmux_pkg::STROBE_W-1:0] pinStrobeA,
  output logic [pfmux_pkg::STROBE_W-1:0] pinStrobeBOut,
  output logic pinStrobeBOe,
  output logic pinWriteA,
  output logic pinWriteB,
  output logic [pfmux_pkg::ADDR_HI:1] pinAddrShared,
  output logic bank01AddrBit0,
  output logic bank23AddrBit0,
  // Pins: ROM select, video decoder or module.
  output logic pinRomSel,
  output logic pinLumaOrActive,
  output logic pinChromaOrSelect,
  input wire logic pinPixclkOrIrq,
  // Pins: feature connector.
  input wire logic syncInEnN,
  input wire logic pixclkInEnN,
  input wire logic videoInEnN,
  input wire logic blankIn,
  input wire logic vsyncIn,
  input wire logic pclkIn,
  input wire logic [pfmux_pkg::STROBE_W-1:0] videoIn,
  // Decoded inputs toward the core.
  output logic [pfmux_pkg::ROM_BYTE_W-1:0] biosRomByte,
  output logic decoderPixelClock,
  output logic moduleIrqRequest,
  output logic videoInVsync,
  output logic videoInField,
  output logic videoInValid,
  output logic extSyncValid,
  output logic extPixclkValid,
  output logic extVideoValid,
  output logic [pfmux_pkg::STROBE_W-1:0] extVideoData
);
  import pfmux_pkg::*;

  // -------------------------------------------------------------------
  // Strap and selections
  // -------------------------------------------------------------------
  logic strapHeld;
  pfmux_strap uStrap (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .strapIn(memDataBusIn[STRAP_BIT]),
    .strapHeld(strapHeld)
  );
  wire moduleSel = (strapHeld == STRAP_MODULE);
  wire videoMode = (fcMode != PFMUX_FC_STANDARD);

  // -------------------------------------------------------------------
  // Pin steering (combinational)
  // -------------------------------------------------------------------
  wire lumaD = moduleSel ? moduleVideoActive : lumaOutEnN;
  wire chromaD = moduleSel ? moduleSelectN : chromaOutEnN;
  // ROM address overrides the low sixteen data lines during ROM cycles.
  wire [MD_WIDTH-1:0] mdOutD = romAccess ?
    {memWrData[MD_WIDTH-1:ROM_ADDR_W], biosRomAddr} : memWrData;
  // The ROM byte lanes must be released so the ROM can drive them.
  wire [MD_WIDTH-1:0] romOeMask = {{(MD_WIDTH-ROM_BYTE_LO-ROM_BYTE_W){1'b1}},
    {ROM_BYTE_W{1'b0}}, {ROM_BYTE_LO{1'b1}}};
  wire [MD_WIDTH-1:0] mdOeD = romAccess ? romOeMask : memWrOe;
  wire [STROBE_W-1:0] strobeAD = oneStrobeDram ? bank01ByteWrN
    : bank01ColStrobeN;
  wire [STROBE_W-1:0] strobeBD = oneStrobeDram ? bank23ByteWrN
    : bank23ColStrobeN;
  wire writeAD = oneStrobeDram ? bank01ColStrobeN[0] : bank01WriteEnN;
  wire writeBD = oneStrobeDram ? bank23ColStrobeN[0] : bank23WriteEnN;
  // Upper video byte owns the shared pins unless 64-bit interleave is on.
  wire [STROBE_W-1:0] pinBD = interleave64 ? strobeBD : videoHiOut;
  wire pinBOeD = interleave64 | videoHiOe;
  wire romSelD = sharedMemOn ? urgentSharedMemReqN : romSelectN;

  // -------------------------------------------------------------------
  // Output registers
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinLumaOrActive <= 1'b1;
      pinChromaOrSelect <= 1'b1;
      memDataBusOut <= '0;
      memDataBusOe <= '0;
      pinStrobeA <= '1;
      pinStrobeBOut <= '1;
      pinStrobeBOe <= 1'b0;
      pinWriteA <= 1'b1;
      pinWriteB <= 1'b1;
      pinAddrShared <= '0;
      bank01AddrBit0 <= 1'b0;
      bank23AddrBit0 <= 1'b0;
      pinRomSel <= 1'b1;
    end else begin
      pinLumaOrActive <= lumaD;
      pinChromaOrSelect <= chromaD;
      memDataBusOut <= mdOutD;
      memDataBusOe <= mdOeD;
      pinStrobeA <= strobeAD;
      pinStrobeBOut <= pinBD;
      pinStrobeBOe <= pinBOeD;
      pinWriteA <= writeAD;
      pinWriteB <= writeBD;
      pinAddrShared <= memAddr[ADDR_HI:1];
      bank01AddrBit0 <= memAddr[0];
      bank23AddrBit0 <= memAddrB[0];
      pinRomSel <= romSelD;
    end
  end

  // -------------------------------------------------------------------
  // Input interpretation
  // -------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      biosRomByte <= '0;
      decoderPixelClock <= 1'b0;
      moduleIrqRequest <= 1'b0;
      videoInVsync <= 1'b0;
      videoInField <= 1'b0;
      videoInValid <= 1'b0;
      extSyncValid <= 1'b0;
      extPixclkValid <= 1'b0;
      extVideoValid <= 1'b0;
      extVideoData <= '0;
    end else begin
      biosRomByte <= memDataBusIn[ROM_BYTE_LO +: ROM_BYTE_W];
      decoderPixelClock <= !moduleSel && pinPixclkOrIrq;
      moduleIrqRequest <= moduleSel && pinPixclkOrIrq;
      videoInVsync <= videoMode && syncInEnN;
      videoInField <= videoMode && pixclkInEnN;
      videoInValid <= videoMode && blankIn;
      // Standard mode: external drive is honoured only under its enable.
      extSyncValid <= !videoMode && !syncInEnN && vsyncIn;
      extPixclkValid <= !videoMode && !pixclkInEnN && pclkIn;
      extVideoValid <= !videoMode && !videoInEnN;
      extVideoData <= (!videoMode && !videoInEnN) ? videoIn : '0;
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  // The first edge after release still shows reset values on the pins, so
  // the one-cycle latency checks start only once the previous edge ran.
  a_luma_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> pinLumaOrActive == $past(moduleSel ? moduleVideoActive : lumaOutEnN))
    else $error("luma pin wrong");
  a_chroma_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> pinChromaOrSelect == $past(moduleSel ? moduleSelectN : chromaOutEnN))
    else $error("chroma pin wrong");
  a_irq_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
    moduleIrqRequest |-> $past(moduleSel))
    else $error("irq seen in decoder mode");
  a_rom_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(romAccess) |-> memDataBusOut[ROM_ADDR_W-1:0] == $past(biosRomAddr))
    else $error("rom address missing");
  a_rom_lanes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(romAccess) |-> memDataBusOe[ROM_BYTE_LO +: ROM_BYTE_W] == '0)
    else $error("rom byte lanes driven");
  a_urgent_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(sharedMemOn) |-> pinRomSel == $past(urgentSharedMemReqN))
    else $error("urgent request not on rom pin");
  a_strobe_swap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(oneStrobeDram) |-> pinStrobeA == $past(bank01ByteWrN)
    && pinWriteA == $past(bank01ColStrobeN[0]))
    else $error("one-strobe swap wrong");
  a_strobe_norm: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && !$past(oneStrobeDram) |-> pinStrobeA == $past(bank01ColStrobeN))
    else $error("strobe pins wrong");
  a_bank23_use: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && !$past(interleave64) |-> pinStrobeBOut == $past(videoHiOut))
    else $error("bank23 strobes outside interleave");
  a_addr_bit0: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> bank23AddrBit0 == $past(memAddrB[0])
    && bank01AddrBit0 == $past(memAddr[0]))
    else $error("address bit0 wrong");
  a_vsync_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
    videoInVsync |-> $past(videoMode && syncInEnN))
    else $error("vsync in wrong mode");
  a_field_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
    videoInField |-> $past(videoMode) && $past(pixclkInEnN))
    else $error("field in wrong mode");
  a_valid_in: assert property (@(posedge clk_sys) disable iff (!rst_n)
    videoInValid |-> $past(videoMode && blankIn))
    else $error("valid in wrong mode");
  a_fc_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
    extVideoValid |-> !$past(videoInEnN) && !$past(videoMode))
    else $error("data taken without enable");
  a_strap_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) |-> $stable(strapHeld))
    else $error("strap changed after reset");
endmodule // pfmux_pin_function_mux

// ===== dv/pfmux_far_side.sv
`timescale 1ns/1ps
module pfmux_far_side (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Strap level fitted on the board.
  input wire logic strapLevel,
  // Memory data pins as the board sees them.
  input wire logic [pfmux_pkg::MD_WIDTH-1:0] memDataBusOut,
  input wire logic [pfmux_pkg::MD_WIDTH-1:0] memDataBusOe,
  input wire logic pinRomSel,
  output logic [pfmux_pkg::MD_WIDTH-1:0] memDataBusIn
);
  import pfmux_pkg::*;
  logic strapPhaseQ;
  logic romDrive;
  // The strap stays up through the first edge after release, which still samples it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strapPhaseQ <= 1'b1;
    end else begin
      strapPhaseQ <= 1'b0;
    end
  end
  // The ROM answers only when selected and its byte lanes are released.
  assign romDrive = !pinRomSel && (memDataBusOe[23:16] == 8'h00);
  // Lines nobody drives fall to the pull-down level, never to the last value.
  always_comb begin
    memDataBusIn = memDataBusOut & memDataBusOe;
    if (romDrive) begin
      memDataBusIn[23:16] = memDataBusOut[7:0] ^ memDataBusOut[15:8] ^ 8'h5a;
    end
    if (strapPhaseQ) begin
      memDataBusIn[STRAP_BIT] = strapLevel;
    end
  end
endmodule // pfmux_far_side

// ===== dv/pin_function_mux_tb.sv
`timescale 1ns/1ps
module pin_function_mux_tb;
  import pfmux_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic strapLevel = 1'b0;
  logic [15:0] lfsrState = 16'hb1f5;
  logic [15:0] romPick;
  logic [7:0] romQ[$];
  int error_cnt = 0;
  int num_checks = 0;
  logic oneStrobeDram, interleave64, sharedMemOn, lumaOutEnN, chromaOutEnN, moduleVideoActive;
  logic moduleSelectN, bank01WriteEnN, bank23WriteEnN, videoHiOe, romAccess, romSelectN;
  logic urgentSharedMemReqN, pinPixclkOrIrq, blankIn, vsyncIn, syncInEnN, pixclkInEnN;
  logic videoInEnN, pclkIn, pinStrobeBOe, pinWriteA, pinWriteB, bank01AddrBit0, bank23AddrBit0;
  logic pinRomSel, pinLumaOrActive, pinChromaOrSelect, decoderPixelClock, moduleIrqRequest;
  logic videoInVsync, videoInField, videoInValid, extSyncValid, extPixclkValid, extVideoValid;
  pfmux_fc_mode_t fcMode;
  logic [STROBE_W-1:0] bank01ColStrobeN, bank23ColStrobeN, bank01ByteWrN, bank23ByteWrN;
  logic [STROBE_W-1:0] videoHiOut, videoIn, pinStrobeA, pinStrobeBOut, extVideoData;
  logic [ADDR_HI:0] memAddr, memAddrB;
  logic [ADDR_HI:1] pinAddrShared;
  logic [MD_WIDTH-1:0] memWrData, memWrOe, memDataBusIn, memDataBusOut, memDataBusOe;
  logic [ROM_ADDR_W-1:0] biosRomAddr;
  logic [ROM_BYTE_W-1:0] biosRomByte;

  always #2.5 clk_sys = ~clk_sys;

  pfmux_pin_function_mux dut_u (.clk_sys, .rst_n, .oneStrobeDram, .interleave64, .sharedMemOn,
    .fcMode, .lumaOutEnN, .chromaOutEnN, .moduleVideoActive, .moduleSelectN, .bank01ColStrobeN,
    .bank23ColStrobeN, .bank01WriteEnN, .bank23WriteEnN, .bank01ByteWrN, .bank23ByteWrN,
    .memAddr, .memAddrB, .memWrData, .memWrOe, .videoHiOut, .videoHiOe, .romAccess, .biosRomAddr,
    .romSelectN, .urgentSharedMemReqN, .memDataBusIn, .memDataBusOut, .memDataBusOe, .pinStrobeA,
    .pinStrobeBOut, .pinStrobeBOe, .pinWriteA, .pinWriteB, .pinAddrShared, .bank01AddrBit0,
    .bank23AddrBit0, .pinRomSel, .pinLumaOrActive, .pinChromaOrSelect, .pinPixclkOrIrq,
    .syncInEnN, .pixclkInEnN, .videoInEnN, .blankIn, .vsyncIn, .pclkIn, .videoIn, .biosRomByte,
    .decoderPixelClock, .moduleIrqRequest, .videoInVsync, .videoInField, .videoInValid,
    .extSyncValid, .extPixclkValid, .extVideoValid, .extVideoData);

  pfmux_far_side far_u (.clk_sys, .rst_n, .strapLevel, .memDataBusOut, .memDataBusOe, .pinRomSel,
    .memDataBusIn);

  // ------------------------------------------------------------
  // Stimulus and reference model
  // ------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsrState = {lfsrState[14:0], lfsrState[15] ^ lfsrState[13] ^ lfsrState[12] ^ lfsrState[10]};
    return lfsrState;
  endfunction

  task automatic drive_rand();
    logic [63:0] v;
    memWrData = {rnd(), rnd(), rnd(), rnd()};
    memWrOe = {rnd(), rnd(), rnd(), rnd()};
    {bank01ColStrobeN, bank23ColStrobeN, bank01ByteWrN, bank23ByteWrN, videoHiOut, videoIn,
      biosRomAddr} = {rnd(), rnd(), rnd(), rnd()};
    v = {rnd(), rnd(), rnd(), rnd()};
    {memAddr, memAddrB} = v[23:0];
    {oneStrobeDram, interleave64, sharedMemOn, lumaOutEnN, chromaOutEnN, moduleVideoActive,
      moduleSelectN, bank01WriteEnN, bank23WriteEnN, videoHiOe, romAccess, romSelectN,
      urgentSharedMemReqN, pinPixclkOrIrq, blankIn, vsyncIn} = v[39:24];
    {syncInEnN, pixclkInEnN, videoInEnN, pclkIn} = v[43:40];
    fcMode = pfmux_fc_mode_t'((v[45:44] == 2'h3) ? 2'h0 : v[45:44]);
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One cycle: drive at the falling edge, compare after the rising edge.
  task automatic cycle(input logic rom, input logic [15:0] a);
    logic [63:0] md;
    logic sm;
    logic vm;
    @(negedge clk_sys);
    drive_rand();
    if (rom) begin
      romAccess = 1'b1;
      romSelectN = 1'b0;
      sharedMemOn = 1'b0;
      biosRomAddr = a;
    end
    #1;
    md = memDataBusIn;
    @(posedge clk_sys);
    #1;
    sm = (strapLevel == STRAP_MODULE);
    vm = (fcMode != PFMUX_FC_STANDARD);
    chk("luma", 64'(sm ? moduleVideoActive : lumaOutEnN), 64'(pinLumaOrActive));
    chk("chroma", 64'(sm ? moduleSelectN : chromaOutEnN), 64'(pinChromaOrSelect));
    chk("pixIrq", 64'({!sm & pinPixclkOrIrq, sm & pinPixclkOrIrq}),
      64'({decoderPixelClock, moduleIrqRequest}));
    if (romAccess) begin
      chk("romAddr", 64'(biosRomAddr), 64'(memDataBusOut[15:0]));
      chk("romLaneOe", 64'h0, 64'(memDataBusOe[23:16]));
    end
    chk("romByte", 64'(md[23:16]), 64'(biosRomByte));
    chk("mdOut", romAccess ? {memWrData[63:16], biosRomAddr} : memWrData,
      memDataBusOut);
    chk("mdOe", romAccess ? 64'hffff_ffff_ff00_ffff : memWrOe, memDataBusOe);
    chk("romSel", 64'(sharedMemOn ? urgentSharedMemReqN : romSelectN), 64'(pinRomSel));
    chk("strobeA", 64'(oneStrobeDram ? bank01ByteWrN : bank01ColStrobeN), 64'(pinStrobeA));
    chk("write", 64'(oneStrobeDram ? {bank01ColStrobeN[0], bank23ColStrobeN[0]} :
      {bank01WriteEnN, bank23WriteEnN}), 64'({pinWriteA, pinWriteB}));
    chk("strobeBOe", 64'(interleave64 | videoHiOe), 64'(pinStrobeBOe));
    if (interleave64 | videoHiOe) begin
      chk("strobeB", 64'(!interleave64 ? videoHiOut : oneStrobeDram ? bank23ByteWrN :
        bank23ColStrobeN), 64'(pinStrobeBOut));
    end
    chk("addr", 64'({memAddr, memAddrB[0]}),
      64'({pinAddrShared, bank01AddrBit0, bank23AddrBit0}));
    chk("vsync", 64'(vm & syncInEnN), 64'(videoInVsync));
    chk("field", 64'(vm & pixclkInEnN), 64'(videoInField));
    chk("valid", 64'(vm & blankIn), 64'(videoInValid));
    // Outside standard mode the feature pins carry video input, so nothing passes here.
    chk("extValid", 64'({!vm & !syncInEnN & vsyncIn, !vm & !pixclkInEnN & pclkIn,
      !vm & !videoInEnN}), 64'({extSyncValid, extPixclkValid, extVideoValid}));
    chk("extData", 64'((vm | videoInEnN) ? 8'h00 : videoIn), 64'(extVideoData));
  endtask

  // ------------------------------------------------------------
  // Verdict
  // ------------------------------------------------------------
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end

  // Both strap levels; the strap line toggles freely after reset to prove the hold.
  initial begin
    drive_rand();
    for (int s = 0; s < 2; s++) begin
      @(negedge clk_sys);
      strapLevel = s[0];
      rst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      for (int i = 0; i < 400; i++) begin
        cycle(1'b0, 16'h0000);
      end
      for (int i = 0; i < 4; i++) begin
        romPick = rnd();
        romQ.push_back(romPick[7:0] ^ romPick[15:8] ^ 8'h5a);
        cycle(1'b1, romPick);
        cycle(1'b1, romPick);
        chk("romRead", 64'(romQ.pop_front()), 64'(biosRomByte));
      end
    end
    end_sim();
  end
endmodule // pin_function_mux_tb
